// ===== rtl/port_regs_cfg.svh
// Offsets, field positions, masks and reset values of the port register slice
`ifndef PORT_REGS_CFG_SVH
`define PORT_REGS_CFG_SVH

`define OFS_SUBSYSTEM_PRODUCT_CODE_CAP 12'h0F0
`define OFS_SUBSYSTEM_PRODUCT_CODE_CODES 12'h0F4
`define OFS_IND_ADDR 12'h0F8
`define OFS_IND_DATA 12'h0FC
`define OFS_AER_CAP 12'h100
`define OFS_UE_FLAGS 12'h104

`define SUBSYSTEM_PRODUCT_CODE_CAP_CONST 32'h0000000D
`define SUBSYSTEM_PRODUCT_CODE_CAP_WMASK 32'h0000FF00
`define SUBSYSTEM_PRODUCT_CODE_CAP_RST 32'h00000000
`define SUBSYSTEM_PRODUCT_CODE_CODES_WMASK 32'hFFFFFFFF
`define SUBSYSTEM_PRODUCT_CODE_CODES_RST 32'h00000000
`define IND_ADDR_WMASK 32'h00000FFC
`define IND_ADDR_RST 32'h00000000
`define AER_CAP_CONST 32'h00010001
`define AER_CAP_WMASK 32'hFFF00000
`define AER_CAP_RST 32'h20000000
`define UE_FLAGS_WMASK 32'h001F3031
`define UE_FLAGS_RST 32'h00000000

`define BIT_OBSOLETE 0
`define BIT_LINK_PROTOCOL 4
`define BIT_SURPRISE_DOWN 5
`define BIT_POISONED 12
`define BIT_FLOW_CONTROL 13
`define BIT_CPL_TIMEOUT 14
`define BIT_CPL_ABORT 15
`define BIT_UNEXP_CPL 16
`define BIT_RX_OVERFLOW 17
`define BIT_MALFORMED 18
`define BIT_ECRC 19
`define BIT_UNSUPPORTED 20

`endif

// ===== rtl/port_regs_pkg.sv
// Types carried by the port register slice
package port_regs_pkg;

   typedef struct packed {
      logic valid;
      logic write;
      logic smbus;
      logic [11:0] addr;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } cfg_rsp_t;

   typedef struct packed {
      logic link_protocol;
      logic surprise_down;
      logic poisoned;
      logic flow_control;
      logic unexpected_cpl;
      logic rx_overflow;
      logic malformed;
      logic ecrc;
      logic unsupported;
   } err_event_t;

endpackage

// ===== rtl/switch_port_config_ext_aer_regs.sv
// Per-port subsystem id, indirect config window and uncorrectable error status registers
// How it works
// RL1: Subsystem id header reads type code 0xD in its low byte.
// RL2: Header bits 15:8 hold a lockable next pointer, reset zero.
// RL3: Maker code in 15:0, product code in 31:16, lockable, reset zero.
// RL4: Indirect address keeps dword index 7:2 and extended index 11:8; rest zero.
// RL5: Reading the data register returns the selected target register.
// RL6: Writing the data register writes the target with its normal write behaviour.
// RL7: Byte enables of the data access apply to the target.
// RL8: Target pointing at the data register reads zero and drops writes.
// RL9: Target pointing at the address register lets data writes change it.
// RL10: Side port accesses to the data register read zero, writes do nothing.
// RL11: Error header reads code 0x1, version 0x1, lockable next pointer 0x200.
// RL12: Bit 4 sets on link protocol error; sticky, write one clears.
// RL13: Bit 5 sets on surprise down; stays zero without that capability.
// RL14: Bits 12 and 13 set on poisoned packet and flow control error.
// RL15: Bits 16 and 17 set on unexpected completion and receiver overflow.
// RL16: Bits 18, 19, 20 set on malformed, end-to-end CRC, unsupported request.
// RL17: Bit 14 completion time-out is hardwired zero.
// RL18: Bit 15 completer abort reads zero.
// RL19: Bit 0 is never set by hardware.
// RL20: Write one clears, zero keeps, a new detection wins over the clear.
// RL21: Sticky flags survive hot reset; only rst clears them.
`timescale 1ns/1ps
`include "port_regs_cfg.svh"

module switch_port_config_ext_aer_regs #(
   parameter int unsigned DATA_W = 32
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hot_rst,
   input wire logic write_lock,
   input wire logic surprise_down_capable,
   input wire port_regs_pkg::cfg_req_t req,
   input wire port_regs_pkg::err_event_t events,
   output port_regs_pkg::cfg_rsp_t rsp,
   output logic [31:0] uncorrectable_error_flags
);
   import port_regs_pkg::*;

   generate
      if (DATA_W != 32) begin : g_bad_width
         $error("Register slice serves 32-bit data only");
      end
   endgenerate

   function automatic logic [9:0] dword(input logic [11:0] a);
      dword = a[11:2];
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] wdata,
      input logic [3:0] be,
      input logic [31:0] wmask
   );
      logic [31:0] m;
      m = lane_mask(be) & wmask;
      merge = (old & ~m) | (wdata & m);
   endfunction

   logic [31:0] subsystem_product_code_cap_reg, subsystem_product_code_cap_next;
   logic [31:0] subsystem_product_code_codes_reg, subsystem_product_code_codes_next;
   logic [31:0] ind_addr_reg, ind_addr_next;
   logic [31:0] aer_cap_reg, aer_cap_next;
   logic [31:0] flags_reg, flags_next;
   cfg_rsp_t rsp_reg, rsp_next;

   // Target chosen by the indirect window
   wire [11:0] ind_target = {ind_addr_reg[11:2], 2'b00};
   wire hit_data = dword(req.addr) == dword(`OFS_IND_DATA);
   wire tgt_is_data = dword(ind_target) == dword(`OFS_IND_DATA);
   wire ind_blocked = req.smbus || tgt_is_data; // [RL8] [RL10]
   wire eff_ok = !hit_data || !ind_blocked;
   wire [11:0] eff_addr = hit_data ? ind_target : req.addr; // [RL5] [RL6]
   wire wr_go = req.valid && req.write && eff_ok && !hot_rst;
   wire rd_go = req.valid && !req.write && !hot_rst;

   function automatic logic [31:0] read_reg(input logic [11:0] a);
      case (dword(a))
         dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CAP): read_reg = (subsystem_product_code_cap_reg & `SUBSYSTEM_PRODUCT_CODE_CAP_WMASK) | `SUBSYSTEM_PRODUCT_CODE_CAP_CONST; // [RL1] [RL2]
         dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES): read_reg = subsystem_product_code_codes_reg; // [RL3]
         dword(`OFS_IND_ADDR): read_reg = ind_addr_reg & `IND_ADDR_WMASK; // [RL4]
         dword(`OFS_AER_CAP): read_reg = (aer_cap_reg & `AER_CAP_WMASK) | `AER_CAP_CONST; // [RL11]
         dword(`OFS_UE_FLAGS): read_reg = flags_reg;
         default: read_reg = 32'h00000000;
      endcase
   endfunction

   wire [31:0] rd_val = eff_ok ? read_reg(eff_addr) : 32'h00000000; // [RL5] [RL8] [RL10]

   wire wr_subsystem_product_code_cap = wr_go && !write_lock && dword(eff_addr) == dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CAP);
   wire wr_subsystem_product_code_codes = wr_go && !write_lock && dword(eff_addr) == dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES);
   wire wr_ind_addr = wr_go && dword(eff_addr) == dword(`OFS_IND_ADDR);
   wire wr_aer_cap = wr_go && !write_lock && dword(eff_addr) == dword(`OFS_AER_CAP);
   wire wr_flags = wr_go && dword(eff_addr) == dword(`OFS_UE_FLAGS);

   // Lanes of the original access carry through the window
   wire [31:0] w1c_clear = wr_flags ? (req.wdata & lane_mask(req.byte_en) & `UE_FLAGS_WMASK) : 32'h00000000; // [RL7]

   wire [31:0] flag_set = (32'h00000001 << `BIT_LINK_PROTOCOL) & {32{events.link_protocol}} // [RL12]
      | (32'h00000001 << `BIT_SURPRISE_DOWN) & {32{events.surprise_down && surprise_down_capable}} // [RL13]
      | (32'h00000001 << `BIT_POISONED) & {32{events.poisoned}} // [RL14]
      | (32'h00000001 << `BIT_FLOW_CONTROL) & {32{events.flow_control}} // [RL14]
      | (32'h00000001 << `BIT_UNEXP_CPL) & {32{events.unexpected_cpl}} // [RL15]
      | (32'h00000001 << `BIT_RX_OVERFLOW) & {32{events.rx_overflow}} // [RL15]
      | (32'h00000001 << `BIT_MALFORMED) & {32{events.malformed}} // [RL16]
      | (32'h00000001 << `BIT_ECRC) & {32{events.ecrc}} // [RL16]
      | (32'h00000001 << `BIT_UNSUPPORTED) & {32{events.unsupported}}; // [RL16]

   // Without the capability the surprise-down flag is held at zero
   wire [31:0] keep_mask = surprise_down_capable ? `UE_FLAGS_WMASK
      : (`UE_FLAGS_WMASK & ~(32'h00000001 << `BIT_SURPRISE_DOWN)); // [RL13] [RL17] [RL18] [RL19]

   assign subsystem_product_code_cap_next = wr_subsystem_product_code_cap ? merge(subsystem_product_code_cap_reg, req.wdata, req.byte_en, `SUBSYSTEM_PRODUCT_CODE_CAP_WMASK)
      : subsystem_product_code_cap_reg; // [RL2] [RL6] [RL7]
   assign subsystem_product_code_codes_next = wr_subsystem_product_code_codes ? merge(subsystem_product_code_codes_reg, req.wdata, req.byte_en, `SUBSYSTEM_PRODUCT_CODE_CODES_WMASK)
      : subsystem_product_code_codes_reg; // [RL3]
   assign ind_addr_next = wr_ind_addr ? merge(ind_addr_reg, req.wdata, req.byte_en, `IND_ADDR_WMASK)
      : ind_addr_reg; // [RL4] [RL9]
   assign aer_cap_next = wr_aer_cap ? merge(aer_cap_reg, req.wdata, req.byte_en, `AER_CAP_WMASK)
      : aer_cap_reg; // [RL11]
   assign flags_next = ((flags_reg & ~w1c_clear) | flag_set) & keep_mask; // [RL20]
   assign rsp_next = '{valid: req.valid, rdata: (rd_go ? rd_val : 32'h00000000)};

   // Sticky flags: only the fundamental reset clears them
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_reg <= `UE_FLAGS_RST;
      end else begin
         flags_reg <= flags_next; // [RL21]
      end
   end

   // Non-sticky state: cleared by either reset
   always_ff @(posedge core_clk) begin
      if (rst || hot_rst) begin
         subsystem_product_code_cap_reg <= `SUBSYSTEM_PRODUCT_CODE_CAP_RST;
         subsystem_product_code_codes_reg <= `SUBSYSTEM_PRODUCT_CODE_CODES_RST;
         ind_addr_reg <= `IND_ADDR_RST;
         aer_cap_reg <= `AER_CAP_RST;
         rsp_reg <= '0;
      end else begin
         subsystem_product_code_cap_reg <= subsystem_product_code_cap_next;
         subsystem_product_code_codes_reg <= subsystem_product_code_codes_next;
         ind_addr_reg <= ind_addr_next;
         aer_cap_reg <= aer_cap_next;
         rsp_reg <= rsp_next;
      end
   end

   assign rsp = rsp_reg;
   assign uncorrectable_error_flags = flags_reg;

   // Checks
   wire rd_direct = rd_go && !hit_data;
   wire rd_window = rd_go && hit_data;

   property p_subsystem_product_code_structure_type_code;
      @(posedge core_clk) disable iff (rst || hot_rst)
      rd_direct && dword(req.addr) == dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CAP) |=> rsp.valid && rsp.rdata[7:0] == 8'h0D;
   endproperty
   a_subsystem_product_code_structure_type_code: assert property (p_subsystem_product_code_structure_type_code) else $error("subsystem id type code wrong"); // [RL1]

   property p_lock_holds;
      @(posedge core_clk) disable iff (rst || hot_rst)
      write_lock |=> $stable(subsystem_product_code_cap_reg) && $stable(subsystem_product_code_codes_reg) && $stable(aer_cap_reg);
   endproperty
   a_lock_holds: assert property (p_lock_holds) else $error("locked field changed"); // [RL2]

   property p_codes_write;
      @(posedge core_clk) disable iff (rst || hot_rst)
      wr_go && !write_lock && !hit_data && dword(req.addr) == dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES) && req.byte_en == 4'hF
      |=> subsystem_product_code_codes_reg == $past(req.wdata);
   endproperty
   a_codes_write: assert property (p_codes_write) else $error("subsystem codes not written"); // [RL3]

   property p_addr_reserved;
      @(posedge core_clk) disable iff (rst)
      ##1 (ind_addr_reg & ~`IND_ADDR_WMASK) == 32'h00000000;
   endproperty
   a_addr_reserved: assert property (p_addr_reserved) else $error("address reserved bits set"); // [RL4]

   property p_window_read;
      @(posedge core_clk) disable iff (rst || hot_rst)
      rd_window && !req.smbus && dword(ind_target) == dword(`OFS_UE_FLAGS) |=> rsp.rdata == $past(flags_reg);
   endproperty
   a_window_read: assert property (p_window_read) else $error("window read mismatch"); // [RL5]

   property p_self_read_zero;
      @(posedge core_clk) disable iff (rst || hot_rst)
      rd_window && (req.smbus || tgt_is_data) |=> rsp.valid && rsp.rdata == 32'h00000000;
   endproperty
   a_self_read_zero: assert property (p_self_read_zero) else $error("blocked window read not zero"); // [RL8]

   property p_window_addr_write;
      @(posedge core_clk) disable iff (rst || hot_rst)
      req.valid && req.write && hit_data && !req.smbus && dword(ind_target) == dword(`OFS_IND_ADDR)
      && req.byte_en == 4'hF |=> ind_addr_reg == ($past(req.wdata) & `IND_ADDR_WMASK);
   endproperty
   a_window_addr_write: assert property (p_window_addr_write) else $error("address not written via window"); // [RL9]

   property p_smbus_no_write;
      @(posedge core_clk) disable iff (rst || hot_rst)
      req.valid && req.write && hit_data && req.smbus && !(|events)
      |=> $stable(ind_addr_reg) && $stable(subsystem_product_code_codes_reg) && $stable(flags_reg);
   endproperty
   a_smbus_no_write: assert property (p_smbus_no_write) else $error("side port write took effect"); // [RL10]

   property p_aer_header;
      @(posedge core_clk) disable iff (rst || hot_rst)
      rd_direct && dword(req.addr) == dword(`OFS_AER_CAP) |=> rsp.rdata[19:0] == 20'h10001;
   endproperty
   a_aer_header: assert property (p_aer_header) else $error("error header code or version wrong"); // [RL11]

   property p_set_wins;
      @(posedge core_clk) disable iff (rst)
      (events.link_protocol |=> flags_reg[`BIT_LINK_PROTOCOL])
      and (events.poisoned |=> flags_reg[`BIT_POISONED]);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("detected error not flagged"); // [RL12] [RL14] [RL20]

   property p_surprise_gate;
      @(posedge core_clk) disable iff (rst)
      !surprise_down_capable |=> !flags_reg[`BIT_SURPRISE_DOWN];
   endproperty
   a_surprise_gate: assert property (p_surprise_gate) else $error("surprise down flagged without capability"); // [RL13]

   property p_fixed_zero;
      @(posedge core_clk) disable iff (rst)
      ##1 !flags_reg[`BIT_CPL_TIMEOUT] && !flags_reg[`BIT_CPL_ABORT] && !flags_reg[`BIT_OBSOLETE];
   endproperty
   a_fixed_zero: assert property (p_fixed_zero) else $error("fixed-zero flag set"); // [RL17] [RL18] [RL19]

   property p_sticky_hot;
      @(posedge core_clk) disable iff (rst)
      hot_rst && !(|events) |=> flags_reg == $past(flags_reg);
   endproperty
   a_sticky_hot: assert property (p_sticky_hot) else $error("sticky flags lost on hot reset"); // [RL21]

   property p_w1c_clear;
      @(posedge core_clk) disable iff (rst || hot_rst)
      wr_flags && req.byte_en[2] && req.wdata[`BIT_UNEXP_CPL] && !events.unexpected_cpl
      |=> !flags_reg[`BIT_UNEXP_CPL];
   endproperty
   a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear"); // [RL15] [RL20]

   property p_rsp_follows;
      @(posedge core_clk) disable iff (rst || hot_rst)
      req.valid |=> rsp.valid;
   endproperty
   a_rsp_follows: assert property (p_rsp_follows) else $error("request not answered"); // [RL5]

   property p_rsp_idle;
      @(posedge core_clk) disable iff (rst || hot_rst)
      !req.valid |=> !rsp.valid;
   endproperty
   a_rsp_idle: assert property (p_rsp_idle) else $error("answer without request"); // [RL5]

   property p_write_rdata_zero;
      @(posedge core_clk) disable iff (rst || hot_rst)
      req.valid && req.write |=> rsp.rdata == 32'h00000000;
   endproperty
   a_write_rdata_zero: assert property (p_write_rdata_zero) else $error("write answer carries data"); // [RL6]

   property p_cap_upper_zero;
      @(posedge core_clk) disable iff (rst || hot_rst)
      rd_direct && dword(req.addr) == dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CAP) |=> rsp.rdata[31:16] == 16'h0000;
   endproperty
   a_cap_upper_zero: assert property (p_cap_upper_zero) else $error("id header upper half not zero"); // [RL1]

   property p_cap_ptr_write;
      @(posedge core_clk) disable iff (rst || hot_rst)
      wr_go && !write_lock && !hit_data && dword(req.addr) == dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CAP) && req.byte_en[1]
      |=> subsystem_product_code_cap_reg[15:8] == $past(req.wdata[15:8]);
   endproperty
   a_cap_ptr_write: assert property (p_cap_ptr_write) else $error("id header pointer not written"); // [RL2]

   property p_codes_read;
      @(posedge core_clk) disable iff (rst || hot_rst)
      rd_direct && dword(req.addr) == dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES) |=> rsp.rdata == $past(subsystem_product_code_codes_reg);
   endproperty
   a_codes_read: assert property (p_codes_read) else $error("subsystem codes read wrong"); // [RL3]

   property p_addr_read;
      @(posedge core_clk) disable iff (rst || hot_rst)
      rd_direct && dword(req.addr) == dword(`OFS_IND_ADDR) |=> rsp.rdata[31:12] == 20'h00000 && rsp.rdata[1:0] == 2'b00;
   endproperty
   a_addr_read: assert property (p_addr_read) else $error("address register reserved bits read"); // [RL4]

   property p_addr_write;
      @(posedge core_clk) disable iff (rst || hot_rst)
      wr_go && !hit_data && dword(req.addr) == dword(`OFS_IND_ADDR) && req.byte_en == 4'hF
      |=> ind_addr_reg[11:2] == $past(req.wdata[11:2]);
   endproperty
   a_addr_write: assert property (p_addr_write) else $error("address index not written"); // [RL4]

   property p_window_lanes;
      @(posedge core_clk) disable iff (rst || hot_rst)
      wr_go && hit_data && dword(ind_target) == dword(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES) && !req.byte_en[3]
      |=> subsystem_product_code_codes_reg[31:24] == $past(subsystem_product_code_codes_reg[31:24]);
   endproperty
   a_window_lanes: assert property (p_window_lanes) else $error("disabled lane written via window"); // [RL7]

   property p_self_write_drop;
      @(posedge core_clk) disable iff (rst || hot_rst)
      req.valid && req.write && hit_data && tgt_is_data
      |=> $stable(ind_addr_reg) && $stable(subsystem_product_code_codes_reg) && $stable(subsystem_product_code_cap_reg) && $stable(aer_cap_reg);
   endproperty
   a_self_write_drop: assert property (p_self_write_drop) else $error("self-targeted write took effect"); // [RL8]

   property p_smbus_read_zero;
      @(posedge core_clk) disable iff (rst || hot_rst)
      rd_window && req.smbus |=> rsp.rdata == 32'h00000000;
   endproperty
   a_smbus_read_zero: assert property (p_smbus_read_zero) else $error("side port window read not zero"); // [RL10]

   property p_aer_ptr_write;
      @(posedge core_clk) disable iff (rst || hot_rst)
      wr_go && !write_lock && !hit_data && dword(req.addr) == dword(`OFS_AER_CAP) && req.byte_en[3] && req.byte_en[2]
      |=> aer_cap_reg[31:20] == $past(req.wdata[31:20]);
   endproperty
   a_aer_ptr_write: assert property (p_aer_ptr_write) else $error("error header pointer not written"); // [RL11]

   property p_aer_ptr_reset;
      @(posedge core_clk) disable iff (rst)
      hot_rst |=> aer_cap_reg == `AER_CAP_RST;
   endproperty
   a_aer_ptr_reset: assert property (p_aer_ptr_reset) else $error("error header pointer not reset"); // [RL11]

   property p_reserved_flags;
      @(posedge core_clk) disable iff (rst)
      ##1 (flags_reg & ~`UE_FLAGS_WMASK) == 32'h00000000;
   endproperty
   a_reserved_flags: assert property (p_reserved_flags) else $error("reserved flag bit set"); // [RL19]

   property p_no_set_without_event;
      @(posedge core_clk) disable iff (rst)
      !events.ecrc |=> !$rose(flags_reg[`BIT_ECRC]);
   endproperty
   a_no_set_without_event: assert property (p_no_set_without_event) else $error("flag set without event"); // [RL16]

   property p_write_never_sets;
      @(posedge core_clk) disable iff (rst || hot_rst)
      wr_flags && !(|events) |=> (flags_reg & ~$past(flags_reg)) == 32'h00000000;
   endproperty
   a_write_never_sets: assert property (p_write_never_sets) else $error("flag write set a bit"); // [RL20]

   property p_surprise_set;
      @(posedge core_clk) disable iff (rst)
      events.surprise_down && surprise_down_capable |=> flags_reg[`BIT_SURPRISE_DOWN];
   endproperty
   a_surprise_set: assert property (p_surprise_set) else $error("surprise down not flagged"); // [RL13]

   property p_rst_clears;
      @(posedge core_clk)
      rst |=> flags_reg == 32'h00000000;
   endproperty
   a_rst_clears: assert property (p_rst_clears) else $error("fundamental reset left flags set"); // [RL21]

   c_window_read: cover property (@(posedge core_clk) disable iff (rst) rd_window && !ind_blocked);
   c_flag_cleared: cover property (@(posedge core_clk) disable iff (rst) flags_reg[`BIT_ECRC] ##1 !flags_reg[`BIT_ECRC]);
   c_smbus_blocked: cover property (@(posedge core_clk) disable iff (rst) rd_window && req.smbus);
   c_hot_keep: cover property (@(posedge core_clk) disable iff (rst) hot_rst && |flags_reg);
   c_set_and_clear: cover property (@(posedge core_clk) disable iff (rst) wr_flags && events.ecrc);

endmodule

// ===== verif/cfg_requester.sv
// Configuration requester model driving the request port of the register slice
`timescale 1ns/1ps

module cfg_requester (
   input wire logic core_clk,
   output port_regs_pkg::cfg_req_t req,
   input wire port_regs_pkg::cfg_rsp_t rsp
);
   import port_regs_pkg::*;

   initial begin
      req = '0;
   end

   // One request, held for one edge, answer picked up 1 ns after the edge that takes it
   task automatic access(input logic wr, input logic sm, input logic [11:0] a, input logic [3:0] be,
                         input logic [31:0] wd, output logic [31:0] rd, output logic v);
      @(posedge core_clk);
      req <= '{valid: 1'b1, write: wr, smbus: sm, addr: a, byte_en: be, wdata: wd};
      @(posedge core_clk);
      req <= '0;
      #1;
      rd = rsp.rdata;
      v = rsp.valid;
   endtask
endmodule

// ===== verif/switch_port_config_ext_aer_regs_tb_top.sv
// Self-checking bench for the port register slice
`timescale 1ns/1ps
`include "port_regs_cfg.svh"

module switch_port_config_ext_aer_regs_tb_top;
   import port_regs_pkg::*;

   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic hot_rst = 1'b0;
   logic write_lock = 1'b0;
   logic sd_capable = 1'b1;
   err_event_t events = '0;
   cfg_req_t req;
   cfg_rsp_t rsp;
   logic [31:0] flags;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   int flag_bits [9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};

   always #5 core_clk = ~core_clk;

   switch_port_config_ext_aer_regs switch_port_config_ext_aer_regs_i (
      .core_clk(core_clk), .rst(rst), .hot_rst(hot_rst), .write_lock(write_lock),
      .surprise_down_capable(sd_capable), .req(req), .events(events), .rsp(rsp),
      .uncorrectable_error_flags(flags)
   );

   cfg_requester cfg_requester_i (.core_clk(core_clk), .req(req), .rsp(rsp));

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Hang guard, well above the length of the sequence
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches = mismatches + 1;
         print_verdict();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF,
                     input logic sm = 1'b0);
      logic [31:0] r;
      logic v;
      cfg_requester_i.access(1'b1, sm, a, be, d, r, v);
      chk("write_answer", 32'h00000001, {31'h0, v});
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic sm = 1'b0);
      logic [31:0] r;
      logic v;
      cfg_requester_i.access(1'b0, sm, a, 4'hF, 32'h0, r, v);
      chk("read_answer", 32'h00000001, {31'h0, v});
      chk($sformatf("read_%h", a), e, r);
   endtask

   task automatic pulse(input err_event_t e);
      @(posedge core_clk);
      events <= e;
      @(posedge core_clk);
      events <= '0;
   endtask

   task automatic reset_pulse(input logic fundamental);
      @(posedge core_clk);
      if (fundamental) rst <= 1'b1; else hot_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      hot_rst <= 1'b0;
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rd(`OFS_SUBSYSTEM_PRODUCT_CODE_CAP, 32'h0000000D);
      rd(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES, 32'h00000000);
      rd(`OFS_IND_ADDR, 32'h00000000);
      rd(`OFS_AER_CAP, 32'h20010001);
      rd(`OFS_UE_FLAGS, 32'h00000000);
      wr(`OFS_SUBSYSTEM_PRODUCT_CODE_CAP, 32'hFFFFFFFF);
      rd(`OFS_SUBSYSTEM_PRODUCT_CODE_CAP, 32'h0000FF0D);
      wr(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES, 32'h12345678);
      rd(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES, 32'h12345678);
      wr(`OFS_AER_CAP, 32'hFFFFFFFF);
      rd(`OFS_AER_CAP, 32'hFFF10001);
      // Locked fields drop direct writes
      @(posedge core_clk);
      write_lock <= 1'b1;
      wr(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES, 32'h00000000);
      wr(`OFS_AER_CAP, 32'h00000000);
      @(posedge core_clk);
      write_lock <= 1'b0;
      rd(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES, 32'h12345678);
      rd(`OFS_AER_CAP, 32'hFFF10001);
      wr(12'h108, 32'hFFFFFFFF);
      rd(12'h108, 32'h00000000);
      wr(`OFS_IND_ADDR, 32'hFFFFFFFF);
      rd(`OFS_IND_ADDR, 32'h00000FFC);
      // Window onto the subsystem codes
      wr(`OFS_IND_ADDR, 32'h000000F4);
      rd(`OFS_IND_DATA, 32'h12345678);
      wr(`OFS_IND_DATA, 32'hAABBCCDD, 4'h3);
      rd(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES, 32'h1234CCDD);
      rd(`OFS_IND_DATA, 32'h00000000, 1'b1);
      wr(`OFS_IND_DATA, 32'h00000000, 4'hF, 1'b1);
      rd(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES, 32'h1234CCDD);
      // Window onto itself
      wr(`OFS_IND_ADDR, 32'h000000FC);
      rd(`OFS_IND_DATA, 32'h00000000);
      wr(`OFS_IND_DATA, 32'h00000F00);
      rd(`OFS_IND_ADDR, 32'h000000FC);
      // Window onto the address register
      wr(`OFS_IND_ADDR, 32'h000000F8);
      wr(`OFS_IND_DATA, 32'h00000104);
      rd(`OFS_IND_ADDR, 32'h00000104);
      // Each detection on its own: set, write zero keeps, write one clears
      for (int i = 0; i < 9; i++) begin
         pulse(err_event_t'(9'h100 >> i));
         rd(`OFS_UE_FLAGS, 32'h1 << flag_bits[i]);
         chk("flags_port", 32'h1 << flag_bits[i], flags);
         rd(`OFS_IND_DATA, 32'h1 << flag_bits[i]);
         wr(`OFS_IND_DATA, 32'h00000000);
         rd(`OFS_UE_FLAGS, 32'h1 << flag_bits[i]);
         wr(`OFS_IND_DATA, 32'h1 << flag_bits[i]);
         rd(`OFS_UE_FLAGS, 32'h00000000);
      end
      // Detection and clear taken at the same edge: the detection wins
      fork
         pulse(err_event_t'(9'h002));
         wr(`OFS_UE_FLAGS, 32'h00080000);
      join
      rd(`OFS_UE_FLAGS, 32'h00080000);
      pulse('1);
      rd(`OFS_UE_FLAGS, 32'h001F3030);
      @(posedge core_clk);
      sd_capable <= 1'b0;
      rd(`OFS_UE_FLAGS, 32'h001F3010);
      pulse(err_event_t'(9'h080));
      rd(`OFS_UE_FLAGS, 32'h001F3010);
      @(posedge core_clk);
      sd_capable <= 1'b1;
      wr(`OFS_UE_FLAGS, 32'hFFFFFFFF, 4'h1);
      rd(`OFS_UE_FLAGS, 32'h001F3000);
      reset_pulse(1'b0);
      rd(`OFS_UE_FLAGS, 32'h001F3000);
      chk("flags_port", 32'h001F3000, flags);
      rd(`OFS_SUBSYSTEM_PRODUCT_CODE_CODES, 32'h00000000);
      rd(`OFS_AER_CAP, 32'h20010001);
      reset_pulse(1'b1);
      rd(`OFS_UE_FLAGS, 32'h00000000);
      print_verdict();
   end
endmodule
